// ==== shared/psl_defs.vh ====
// Constants for the primary-side lock, reset and subsystem identification block.
// Assumes inclusion by plain Verilog-2005 design files of this block only.
`ifndef PSL_DEFS_VH
`define PSL_DEFS_VH

// Configuration dword offsets.
`define PSL_OFF_SUBSYS      8'h40
`define PSL_OFF_SUBSYS_ID   8'h42
`define PSL_OFF_SYSCTRL     8'h80
`define PSL_OFF_MFROUTE     8'h8c

// Field positions.
`define PSL_WP_BIT          5
`define PSL_LOCKSEL_HI      19
`define PSL_LOCKSEL_LO      16
`define PSL_LOCKSEL_VAL     4'h1

// Reset values.
`define PSL_SYSCTRL_RST     32'h0000_0020
`define PSL_MFROUTE_RST     32'h0000_0000
`define PSL_SUBSYS_RST      32'h0000_0000

// Lock granule: 16-byte aligned block, so address bits 3..0 are ignored.
`define PSL_LOCK_LSB        4

// Serial EEPROM loader timing.
`define PSL_CLK_HZ          50000000
`define PSL_SCL_HZ          100000
`define PSL_SCL_DIV         (`PSL_CLK_HZ / (`PSL_SCL_HZ * 4))
`define PSL_EE_DEV_ADDR     7'h50
`define PSL_EE_WORD_ADDR    8'h00

`endif

// ==== rtl/psl_ee_loader.v ====
// Two-wire serial-bus host that reads four bytes from a serial EEPROM.
// Assumes the clock is sys_clk and the EEPROM holds the identifier at word 0.
`timescale 1ns/1ps
`default_nettype none
`include "psl_defs.vh"

module psl_ee_loader #(
	parameter DIV = `PSL_SCL_DIV
) (
	// Clock and reset.
	input  wire        sys_clk,
	input  wire        srst,
	// Control.
	input  wire        start,
	output reg         busy,
	output reg         done,
	output reg         fail,
	output reg  [31:0] data,
	// Serial bus, open drain.
	input  wire        scl_in,
	output reg         scl_oe,
	input  wire        sda_in,
	output reg         sda_oe
);
	localparam S_IDLE = 3'd0;
	localparam S_START = 3'd1;
	localparam S_BIT = 3'd2;
	localparam S_STOP = 3'd3;
	localparam S_RSTART = 3'd4;

	reg [15:0] div_cnt;
	reg        tick;
	reg [2:0]  state;
	reg [1:0]  phase;
	reg [3:0]  bit_cnt;
	reg [2:0]  byte_cnt;
	reg [8:0]  shreg;

	// Quarter-bit enable pulse; the bus is slow so one divider serves all phases.
	always @(posedge sys_clk) begin
		if (srst || !busy) begin
			div_cnt <= 16'h0000;
			tick <= 1'b0;
		end else if (div_cnt == DIV[15:0] - 16'h0001) begin
			div_cnt <= 16'h0000;
			tick <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 16'h0001;
			tick <= 1'b0;
		end
	end

	// Byte sequence: device write, word address, device read, four data bytes.
	function [8:0] tx_byte;
		input [2:0] idx;
		begin
			case (idx)
			3'd0: tx_byte = {`PSL_EE_DEV_ADDR, 1'b0, 1'b1};
			3'd1: tx_byte = {`PSL_EE_WORD_ADDR, 1'b1};
			3'd2: tx_byte = {`PSL_EE_DEV_ADDR, 1'b1, 1'b1};
			3'd6: tx_byte = 9'h1ff;
			default: tx_byte = 9'h1fe;
			endcase
		end
	endfunction

	// Bit engine; data bytes 3..5 are acknowledged by us, the last is not.
	always @(posedge sys_clk) begin
		if (srst) begin
			state <= S_IDLE;
			phase <= 2'd0;
			bit_cnt <= 4'h0;
			byte_cnt <= 3'd0;
			shreg <= 9'h000;
			busy <= 1'b0;
			done <= 1'b0;
			fail <= 1'b0;
			data <= `PSL_SUBSYS_RST;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
			S_IDLE: begin
				scl_oe <= 1'b0;
				sda_oe <= 1'b0;
				if (start) begin
					busy <= 1'b1;
					fail <= 1'b0;
					byte_cnt <= 3'd0;
					phase <= 2'd0;
					state <= S_START;
				end
			end
			S_START, S_RSTART: if (tick) begin
				phase <= phase + 2'd1;
				case (phase)
				2'd0: begin
					sda_oe <= 1'b0;
					scl_oe <= 1'b0;
				end
				2'd1: sda_oe <= 1'b1;
				2'd2: scl_oe <= 1'b1;
				default: begin
					shreg <= tx_byte(byte_cnt);
					bit_cnt <= 4'h0;
					state <= S_BIT;
				end
				endcase
			end
			S_BIT: if (tick) begin
				phase <= phase + 2'd1;
				case (phase)
				2'd0: sda_oe <= ~shreg[8];
				2'd1: scl_oe <= 1'b0;
				2'd2: begin
					if (scl_in) begin
						shreg <= {shreg[7:0], sda_in};
					end else begin
						phase <= phase; // Clock stretched by the slave.
					end
				end
				default: begin
					scl_oe <= 1'b1;
					bit_cnt <= bit_cnt + 4'h1;
					if (bit_cnt == 4'h8) begin
						if (byte_cnt < 3'd3 && shreg[0]) begin
							fail <= 1'b1;
							state <= S_STOP;
						end else begin
							if (byte_cnt >= 3'd3) begin
								data <= {shreg[8:1], data[31:8]};
							end
							byte_cnt <= byte_cnt + 3'd1;
							if (byte_cnt == 3'd1) begin
								state <= S_RSTART;
							end else if (byte_cnt == 3'd6) begin
								state <= S_STOP;
							end else begin
								shreg <= tx_byte(byte_cnt + 3'd1);
								bit_cnt <= 4'h0;
							end
						end
					end
				end
				endcase
			end
			S_STOP: if (tick) begin
				phase <= phase + 2'd1;
				case (phase)
				2'd0: sda_oe <= 1'b1;
				2'd1: scl_oe <= 1'b0;
				2'd2: sda_oe <= 1'b0;
				default: begin
					busy <= 1'b0;
					done <= ~fail;
					state <= S_IDLE;
				end
				endcase
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule

`default_nettype wire

// ==== rtl/psl_bridge_ctrl.v ====
// Primary-side control: reset qualification, downstream lock, subsystem identifier.
// Assumes all inputs are synchronous to sys_clk and a PCI target decoder outside.
`timescale 1ns/1ps
`default_nettype none
`include "psl_defs.vh"

// What this block does
// - Outputs stay released while global reset is asserted.
// - Lock reaches shared pin 4 only when routing bits 19..16 select it.
// - Locks honoured downstream only, never for card-initiated upstream cycles.
// - Other initiators still reach unlocked addresses while lock held.
// - Bus grant alone never confers lock; lock taken by its own handshake.
// - Locked resource is the whole aligned 16-byte block.
// - Write posting off while locked, back on after release.
// - Downstream lock forwarded on the card-bus lock signal.
// - Vendor identifier at 40h, subsystem identifier at 42h, one dword.
// - Identifier registers read-only unless write-protect bit 5 at 80h cleared.
// - After each primary bus reset, identifier loads from serial EEPROM.
// - Suspend blocks bus reset from reaching the lock tracker, access filter and loader.
// - Optional interrupt A output provided beside mandatory signals.
module psl_bridge_ctrl #(
	parameter EE_DIV = `PSL_SCL_DIV
) (
	// Clock and resets.
	input  wire        sys_clk,
	input  wire        srst,
	input  wire        global_reset_n,
	input  wire        pci_bus_reset_n,
	input  wire        suspend,
	// Configuration access, one dword per cycle.
	input  wire        cfg_wr,
	input  wire        cfg_rd,
	input  wire [7:0]  cfg_addr,
	input  wire [3:0]  cfg_be,
	input  wire [31:0] cfg_wdata,
	output reg  [31:0] cfg_rdata,
	output reg         cfg_rvalid,
	// Primary transaction observation.
	input  wire        txn_start,
	input  wire        txn_upstream,
	input  wire        txn_write,
	input  wire [31:0] txn_addr,
	input  wire        txn_lock_n,
	input  wire        txn_lock_master,
	output reg         txn_retry,
	output reg         post_enable,
	// Lock routing.
	output reg         shared_function_pin_4,
	output reg         shared_function_pin_4_oe,
	output reg         cblock_out_n,
	output reg         cblock_oe,
	// Interrupt A, open drain.
	input  wire        card_irq,
	output reg         inta_oe,
	// Serial EEPROM.
	input  wire        scl_in,
	output reg         scl_oe,
	input  wire        sda_in,
	output reg         sda_oe,
	// Status.
	output reg         ee_loading,
	output reg         ee_fail
);
	// Configuration dwords held here.
	reg  [31:0] sysctrl;
	reg  [31:0] mfroute;
	reg  [31:0] subsys;

	// Lock owner state and the block it protects.
	reg         lock_held;
	reg  [27:0] lock_block;

	// Reset tree and loader handshake.
	reg         pci_bus_reset_n_q;
	reg         ee_start;
	wire        core_rst;
	wire        prim_rst;

	// Loader outputs before retiming.
	wire        ee_busy;
	wire        ee_done;
	wire        ee_fail_w;
	wire [31:0] ee_data;
	wire        ee_scl_oe;
	wire        ee_sda_oe;

	// Decoded levels and strobes.
	wire        lock_route;
	wire        lock_live;
	wire        id_writable;
	wire        wr_subsys;
	wire        wr_sysctrl;
	wire        wr_mfroute;
	wire        block_hit;

	// Dword offsets of the decoded registers; only address bits 7..2 take part.
	// Holding them as sized constants keeps every decode compare six bits wide.
	localparam [7:0] OFF_SUBSYS  = `PSL_OFF_SUBSYS;
	localparam [7:0] OFF_SYSCTRL = `PSL_OFF_SYSCTRL;
	localparam [7:0] OFF_MFROUTE = `PSL_OFF_MFROUTE;

	// Reset tree. Global reset and the local reset clear everything, registers
	// included. The primary bus reset only reaches the lock tracker, the access
	// filter and the serial loader, and suspend cuts it off so that a sleeping
	// host cannot wipe the identifier or restart a load.
	assign core_rst = srst | ~global_reset_n;
	assign prim_rst = core_rst | (~pci_bus_reset_n & ~suspend);
	// The external sequencing of the two resets is trusted, not checked.
	assign lock_route = mfroute[`PSL_LOCKSEL_HI:`PSL_LOCKSEL_LO] == `PSL_LOCKSEL_VAL;

	// Lock as the pins show it. A bus reset clears the tracker one edge late, so
	// it is masked here; otherwise the card lock would linger for a cycle after
	// posting has already come back on.
	assign lock_live = lock_held & ~prim_rst;

	// Write decode. The identifier dword opens only while the protect bit is clear;
	// the other two registers are always writable. A write to a protected
	// identifier is dropped silently, as a read-only register would.
	assign id_writable = ~sysctrl[`PSL_WP_BIT];
	assign wr_subsys = cfg_wr & (cfg_addr[7:2] == OFF_SUBSYS[7:2]) & id_writable;
	assign wr_sysctrl = cfg_wr & (cfg_addr[7:2] == OFF_SYSCTRL[7:2]);
	assign wr_mfroute = cfg_wr & (cfg_addr[7:2] == OFF_MFROUTE[7:2]);

	// An access lands in the locked block when its 16-byte aligned address matches.
	// Only the upper address bits are compared, so any byte in the block counts.
	assign block_hit = txn_addr[31:`PSL_LOCK_LSB] == lock_block;

	// Byte-lane merge shared by every writable register.
	// Lanes whose enable is low keep their old contents.
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  be;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i]) begin
					merge[i*8 +: 8] = nw[i*8 +: 8];
				end
			end
		end
	endfunction

	// Serial loader; its reset follows the gated primary reset so suspend holds it too.
	// Its pin enables are retimed below, so they leave the block from flip-flops.
	psl_ee_loader #(
		.DIV (EE_DIV)
	) u_loader (
		.sys_clk (sys_clk),
		.srst    (prim_rst),
		.start   (ee_start),
		.busy    (ee_busy),
		.done    (ee_done),
		.fail    (ee_fail_w),
		.data    (ee_data),
		.scl_in  (scl_in),
		.scl_oe  (ee_scl_oe),
		.sda_in  (sda_in),
		.sda_oe  (ee_sda_oe)
	);

	// Kick the loader once on each release of the primary reset.
	// The previous reset level is held high through global reset, so the first
	// load after power-up starts as well. While suspend blocks the bus reset no
	// release is ever seen, so no load starts either.
	always @(posedge sys_clk) begin
		if (core_rst) begin
			pci_bus_reset_n_q <= 1'b1;
			ee_start <= 1'b0;
		end else begin
			pci_bus_reset_n_q <= prim_rst;
			ee_start <= pci_bus_reset_n_q & ~prim_rst;
		end
	end

	// Configuration registers; identifier writes only while write-protect is clear.
	// A finished serial load and a firmware write in the same cycle both aim at the
	// identifier; the load wins, since it reflects the board that is really fitted.
	always @(posedge sys_clk) begin
		if (core_rst) begin
			sysctrl <= `PSL_SYSCTRL_RST;
			mfroute <= `PSL_MFROUTE_RST;
			subsys <= `PSL_SUBSYS_RST;
		end else begin
			if (ee_done) begin
				subsys <= ee_data;
			end else if (wr_subsys) begin
				subsys <= merge(subsys, cfg_wdata, cfg_be);
			end
			// Firmware is trusted to set protection back afterwards.
			if (wr_sysctrl) begin
				sysctrl <= merge(sysctrl, cfg_wdata, cfg_be);
			end
			// The routing register decides whether the lock reaches shared pin 4.
			if (wr_mfroute) begin
				mfroute <= merge(mfroute, cfg_wdata, cfg_be);
			end
		end
	end

	// Read mux; vendor word in the low half, subsystem word in the high half.
	// The data register follows the address every cycle, so it is valid in the
	// cycle after the read strobe; unmapped dwords read as zero.
	always @(posedge sys_clk) begin
		if (core_rst) begin
			cfg_rdata <= 32'h0000_0000;
			cfg_rvalid <= 1'b0;
		end else begin
			cfg_rvalid <= cfg_rd;
			case (cfg_addr[7:2])
			OFF_SUBSYS[7:2]: cfg_rdata <= subsys;
			OFF_SYSCTRL[7:2]: cfg_rdata <= sysctrl;
			OFF_MFROUTE[7:2]: cfg_rdata <= mfroute;
			default: cfg_rdata <= 32'h0000_0000;
			endcase
		end
	end

	// Lock tracker: owner takes it by its own handshake on an unlocked bus.
	// A locked access with lock released on the pin frees the block.
	// Winning arbitration alone never counts: the lock pin must be low in the
	// address phase. Card-initiated cycles heading upstream never lock.
	// Only one block is tracked; that is all a single lock owner can hold.
	always @(posedge sys_clk) begin
		if (prim_rst) begin
			lock_held <= 1'b0;
			lock_block <= 28'h000_0000;
		end else if (!lock_held) begin
			if (txn_start && txn_lock_master && !txn_upstream && !txn_lock_n) begin
				lock_held <= 1'b1;
				lock_block <= txn_addr[31:`PSL_LOCK_LSB];
			end
		end else if (txn_lock_n && txn_lock_master) begin
			lock_held <= 1'b0;
		end
	end

	// Access filter: retry only non-owners hitting the locked block.
	// Accesses outside the block, and all upstream ones, pass untouched; posting is
	// held off for the whole locked period to keep write order behind the lock.
	always @(posedge sys_clk) begin
		if (prim_rst) begin
			txn_retry <= 1'b0;
			post_enable <= 1'b1;
		end else begin
			txn_retry <= txn_start && lock_held && !txn_lock_master && !txn_upstream &&
				block_hit;
			post_enable <= ~lock_held;
		end
	end

	// Lock pins: all released while global reset is asserted.
	// The lock pin mirrors the owner's lock when routed; a limitation is that
	// only the owner's qualification is shown, not other agents' use of it.
	always @(posedge sys_clk) begin
		if (core_rst) begin
			shared_function_pin_4 <= 1'b1;
			shared_function_pin_4_oe <= 1'b0;
			cblock_out_n <= 1'b1;
			cblock_oe <= 1'b0;
		end else begin
			shared_function_pin_4 <= ~lock_live;
			shared_function_pin_4_oe <= lock_route;
			cblock_out_n <= ~lock_live;
			cblock_oe <= lock_live;
		end
	end

	// Interrupt A drive; the card's request is passed on one clock late.
	always @(posedge sys_clk) begin
		if (core_rst) begin
			inta_oe <= 1'b0;
		end else begin
			inta_oe <= card_irq;
		end
	end

	// Serial bus drives and loader status, retimed so every output leaves a flip-flop.
	// The extra cycle of delay is small against a quarter-bit period.
	always @(posedge sys_clk) begin
		if (core_rst) begin
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			ee_loading <= 1'b0;
			ee_fail <= 1'b0;
		end else begin
			scl_oe <= ee_scl_oe;
			sda_oe <= ee_sda_oe;
			ee_loading <= ee_busy;
			ee_fail <= ee_fail_w;
		end
	end
endmodule

`default_nettype wire

// ==== tb/psl_ee_partner.sv ====
// Two-wire bus with pull-ups and an EEPROM slot left empty.
// Assumes open-drain enables that are high while the host pulls a line low.
`timescale 1ns/1ps
`default_nettype none
module psl_ee_partner (
	// Host drive enables.
	input  wire logic scl_oe,
	input  wire logic sda_oe,
	// Resolved line levels.
	output logic      scl_in,
	output logic      sda_in
);
	// Nobody answers, so each acknowledge slot sees the pulled-up line and reads as refused.
	assign scl_in = ~scl_oe;
	assign sda_in = ~sda_oe;
endmodule
`default_nettype wire

// ==== tb/psl_bridge_ctrl_properties.sv ====
// Checker for the primary-side control block, bound to its top module.
// Assumes one clock domain and level resets as seen at the top ports.
`timescale 1ns/1ps
`default_nettype none
module psl_bridge_props (
	// Clock and resets.
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic global_reset_n,
	input wire logic pci_bus_reset_n,
	input wire logic suspend,
	// Requests and answers.
	input wire logic cfg_rd,
	input wire logic cfg_rvalid,
	input wire logic txn_start,
	input wire logic txn_upstream,
	input wire logic txn_lock_n,
	input wire logic txn_lock_master,
	input wire logic txn_retry,
	input wire logic post_enable,
	// Pin drives.
	input wire logic shared_function_pin_4,
	input wire logic shared_function_pin_4_oe,
	input wire logic cblock_out_n,
	input wire logic cblock_oe,
	input wire logic inta_oe,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic ee_loading
);
	// Global reset acts as a reset too, so it gates all checks but its own.
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst || !global_reset_n);
	sequence s_lock_req;
		txn_start && txn_lock_master && !txn_upstream && !txn_lock_n && post_enable;
	endsequence
	sequence s_bus_release;
		!pci_bus_reset_n && !suspend ##1 pci_bus_reset_n;
	endsequence
	property p_released;
		disable iff (srst) !global_reset_n |=>
			!(cblock_oe || inta_oe || scl_oe || sda_oe || shared_function_pin_4_oe);
	endproperty
	property p_lock_taken;
		s_lock_req |-> ##2 (cblock_oe && !post_enable);
	endproperty
	property p_post_off;
		post_enable != cblock_oe;
	endproperty
	property p_cb_drive;
		cblock_oe |-> !cblock_out_n;
	endproperty
	property p_pin4;
		$rose(cblock_oe) && shared_function_pin_4_oe |-> !shared_function_pin_4;
	endproperty
	property p_up_no_retry;
		txn_start && txn_upstream |=> !txn_retry;
	endproperty
	property p_retry_cause;
		txn_retry |-> $past(txn_start) && !$past(txn_upstream) && !$past(txn_lock_master);
	endproperty
	property p_rd_answer;
		cfg_rd |=> cfg_rvalid;
	endproperty
	property p_loader_start;
		s_bus_release |-> ##[1:3] ee_loading;
	endproperty
	property p_suspend_gate;
		suspend && !ee_loading |=> !ee_loading;
	endproperty
	a_released: assert property (p_released) else $error("pin driven in reset");
	a_lock_taken: assert property (p_lock_taken) else $error("lock not taken");
	a_post_off: assert property (p_post_off) else $error("posting while locked");
	a_cb_drive: assert property (p_cb_drive) else $error("card lock level");
	a_pin4: assert property (p_pin4) else $error("pin 4 lock level");
	a_up_no_retry: assert property (p_up_no_retry) else $error("upstream retried");
	a_retry_cause: assert property (p_retry_cause) else $error("stray retry");
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	a_loader_start: assert property (p_loader_start) else $error("no load");
	a_suspend_gate: assert property (p_suspend_gate) else $error("load in suspend");
endmodule
bind psl_bridge_ctrl psl_bridge_props u_props (.sys_clk(sys_clk), .srst(srst),
	.global_reset_n(global_reset_n), .pci_bus_reset_n(pci_bus_reset_n), .suspend(suspend),
	.cfg_rd(cfg_rd), .cfg_rvalid(cfg_rvalid), .txn_start(txn_start),
	.txn_upstream(txn_upstream), .txn_lock_n(txn_lock_n), .txn_lock_master(txn_lock_master),
	.txn_retry(txn_retry), .post_enable(post_enable),
	.shared_function_pin_4(shared_function_pin_4),
	.shared_function_pin_4_oe(shared_function_pin_4_oe), .cblock_out_n(cblock_out_n),
	.cblock_oe(cblock_oe), .inta_oe(inta_oe), .scl_oe(scl_oe), .sda_oe(sda_oe),
	.ee_loading(ee_loading));
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the primary-side control block.
// Assumes the design, its header, the partner and the checker compile first.
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [3:0] be; logic [31:0] e;} psl_row_t;
	// Design inputs, valued at time zero; all three resets start asserted.
	logic        sys_clk = 1'b0, srst = 1'b1, global_reset_n = 1'b0, pci_bus_reset_n = 1'b0;
	logic        suspend = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, card_irq = 1'b0;
	logic [7:0]  cfg_addr = 8'h00;
	logic [3:0]  cfg_be = 4'h0;
	logic [31:0] cfg_wdata = 32'h0, txn_addr = 32'h0, q;
	logic        txn_start = 1'b0, txn_upstream = 1'b0, txn_lock_n = 1'b1, txn_lock_master = 1'b0;
	logic        r;
	// Design outputs.
	wire  [31:0] cfg_rdata;
	wire         cfg_rvalid, txn_retry, post_enable, pin4, pin4_oe, cb_n, cb_oe, inta_oe;
	wire         scl_oe, sda_oe, scl_in, sda_in, ee_loading, ee_fail;
	int          miscompares = 0, check_count = 0, cycles = 0, n;
	// Register rows: address, write data, byte enables (zero means read only), expected read.
	psl_row_t rows[9] = '{
		'{8'h80, 32'h0, 4'h0, 32'h20},
		'{8'h40, 32'h1234_abcd, 4'hf, 32'h0},
		'{8'h80, 32'h0, 4'hf, 32'h0},
		'{8'h40, 32'h1234_abcd, 4'hf, 32'h1234_abcd},
		'{8'h40, 32'h0000_ffff, 4'hc, 32'h0000_abcd},
		'{8'h80, 32'h20, 4'hf, 32'h20},
		'{8'h40, 32'hffff_ffff, 4'hf, 32'h0000_abcd},
		'{8'h44, 32'hffff_ffff, 4'hf, 32'h0},
		'{8'h8c, 32'h0001_0000, 4'hf, 32'h0001_0000}};

	psl_bridge_ctrl #(.EE_DIV(2)) u_psl_bridge_ctrl (.sys_clk(sys_clk), .srst(srst),
		.global_reset_n(global_reset_n), .pci_bus_reset_n(pci_bus_reset_n), .suspend(suspend),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
		.txn_start(txn_start), .txn_upstream(txn_upstream), .txn_write(1'b0),
		.txn_addr(txn_addr), .txn_lock_n(txn_lock_n), .txn_lock_master(txn_lock_master),
		.txn_retry(txn_retry), .post_enable(post_enable), .shared_function_pin_4(pin4),
		.shared_function_pin_4_oe(pin4_oe), .cblock_out_n(cb_n), .cblock_oe(cb_oe),
		.card_irq(card_irq), .inta_oe(inta_oe), .scl_in(scl_in), .scl_oe(scl_oe),
		.sda_in(sda_in), .sda_oe(sda_oe), .ee_loading(ee_loading), .ee_fail(ee_fail));
	psl_ee_partner u_partner (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));

	always #10 sys_clk = ~sys_clk;
	// A hang is cut short well past the few thousand cycles the run needs.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Optional write, then a read back of the same dword.
	task automatic cfg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge sys_clk);
		cfg_wr <= (be != 4'h0);
		cfg_addr <= a;
		cfg_be <= be;
		cfg_wdata <= d;
		@(posedge sys_clk);
		cfg_wr <= 1'b0;
		cfg_rd <= 1'b1;
		@(posedge sys_clk);
		cfg_rd <= 1'b0;
		#1 chk("read valid", 32'h1, {31'h0, cfg_rvalid});
		q = cfg_rdata;
	endtask

	// One address phase; retry is taken a cycle later, lock effects a cycle after that.
	task automatic txn(input logic [31:0] a, input logic m, input logic up, input logic ln);
		@(posedge sys_clk);
		txn_start <= 1'b1;
		txn_addr <= a;
		txn_lock_master <= m;
		txn_upstream <= up;
		txn_lock_n <= ln;
		@(posedge sys_clk);
		txn_start <= 1'b0;
		#1 r = txn_retry;
		@(posedge sys_clk);
		#1;
	endtask

	initial begin
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		// Global reset stays low 100 us, 5000 cycles, after the clock is stable.
		repeat (5000) @(posedge sys_clk);
		#1 chk("drives at power-up", 32'h0, {cb_oe, inta_oe, scl_oe, sda_oe, pin4_oe});
		@(posedge sys_clk);
		global_reset_n <= 1'b1;
		pci_bus_reset_n <= 1'b1;
		foreach (rows[i]) begin
			cfg(rows[i].a, rows[i].d, rows[i].be);
			chk("config row", rows[i].e, q);
		end
		card_irq <= 1'b1;
		txn(32'h1000, 1'b1, 1'b0, 1'b0);
		chk("posting", 32'h0, {31'h0, post_enable});
		chk("card lock", 32'h2, {30'h0, cb_oe, cb_n});
		chk("pin 4", 32'h2, {30'h0, pin4_oe, pin4});
		txn(32'h100c, 1'b0, 1'b0, 1'b0);
		chk("retry in block", 32'h1, {31'h0, r});
		txn(32'h1010, 1'b0, 1'b0, 1'b0);
		chk("retry next block", 32'h0, {31'h0, r});
		txn(32'h1000, 1'b0, 1'b1, 1'b0);
		chk("upstream retry", 32'h0, {31'h0, r});
		chk("interrupt drive", 32'h1, {31'h0, inta_oe});
		txn(32'h1000, 1'b1, 1'b0, 1'b1);
		chk("posting back", 32'h1, {31'h0, post_enable});
		txn(32'h2000, 1'b1, 1'b1, 1'b0);
		chk("upstream lock", 32'h1, {31'h0, post_enable});
		txn(32'h2000, 1'b1, 1'b0, 1'b1);
		chk("grant only", 32'h1, {31'h0, post_enable});
		txn(32'h3000, 1'b1, 1'b0, 1'b0);
		global_reset_n <= 1'b0;
		pci_bus_reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 chk("drives in reset", 32'h0, {cb_oe, inta_oe, scl_oe, sda_oe, pin4_oe});
		global_reset_n <= 1'b1;
		@(posedge sys_clk);
		pci_bus_reset_n <= 1'b1;
		n = 0;
		while (!ee_loading && n < 10) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk("load started", 32'h1, {31'h0, ee_loading});
		while (ee_loading && n < 5000) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		#1 chk("load refused", 32'h1, {31'h0, ee_fail});
		suspend <= 1'b1;
		@(posedge sys_clk);
		pci_bus_reset_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		pci_bus_reset_n <= 1'b1;
		repeat (5) @(posedge sys_clk);
		// Suspend holds the loader: the refused result stays and no new load starts.
		#1 chk("gated reset", 32'h2, {30'h0, ee_fail, ee_loading});
		end_of_test();
	end
endmodule
`default_nettype wire
